// ===== logic/timer01_consts.vh
`ifndef TIMER01_CONSTS_VH
`define TIMER01_CONSTS_VH

// Register indices as printed; byte address is four times the index.
`define IDX_CTRL_STATUS 8'h88
`define IDX_MODE_CFG    8'h89
`define IDX_T0_LOW      8'h8a
`define IDX_T1_LOW      8'h8b
`define IDX_T0_HIGH     8'h8c
`define IDX_T1_HIGH     8'h8d
`define IDX_CLK_SEL     8'h8f
// Own registers for the outside-of-table bits (polarities and timer 2/3 selects, then vector acks).
`define IDX_AUX_CFG     8'h90
`define IDX_VECTOR_ACK  8'h91

// Control/status field positions.
`define B_T1_OVF   7
`define B_T1_RUN   6
`define B_T0_OVF   5
`define B_T0_RUN   4
`define B_E1_FLAG  3
`define B_E1_TYPE  2
`define B_E0_FLAG  1
`define B_E0_TYPE  0
// Mode config field positions.
`define B_T1_GATE  7
`define B_T1_CNT   6
`define B_T0_GATE  3
`define B_T0_CNT   2
// Clock select field positions.
`define B_T3_HI    7
`define B_T3_LO    6
`define B_T2_HI    5
`define B_T2_LO    4
`define B_T1_SYS   3
`define B_T0_SYS   2
// Aux config field positions.
`define B_E0_POL   0
`define B_E1_POL   1
`define B_T2_XCLK  2
`define B_T3_XCLK  3
`define B_T2_SPLIT 4
`define B_T3_SPLIT 5

`define RESET_BYTE 8'h00
// Prescale divisors; the external divide-by-eight is given as its last count, 7.
`define DIV_SYS12  6'd12
`define DIV_SYS4   6'd4
`define DIV_SYS48  6'd48
`define DIV_EXT8   3'd7

`endif

// ===== logic/dual_counter_timer_ctrl.v
// Operation
// - Timer one overflow sets its flag; cleared by write or on vectoring.
// - Timer zero overflow sets its flag; cleared by write or on vectoring.
// - Run bits enable timers when 1, disable when 0.
// - External one flag set by edge or level; edge clears on vectoring.
// - External zero flag behaves like external one flag.
// - Type select: 0 level triggered, 1 edge triggered.
// - Timer one gate makes counting also need active external one input.
// - Timer zero gate makes counting also need active external zero input.
// - Timer one counts selected clock, or falling edges of its event pin.
// - Timer zero counts selected clock, or falling edges of its event pin.
// - Timer one modes: 13-bit, 16-bit, 8-bit reload, inactive.
// - Timer zero modes: 13-bit, 16-bit, 8-bit reload, two 8-bit.
// - Timer one picks prescaled or system clock unless counting events.
// - Timer zero picks prescaled or system clock unless counting events.
// - Prescale: sysclk/12, sysclk/4, sysclk/48, or external clock/8.
// - External clock divided by eight is synchronized before use.
// - Timer three high byte clock select applies only in split mode.
// - Timer three low clock select picks external source or system clock.
// - Timer two high byte clock select applies only in split mode.
// - Timer two low clock select picks external source or system clock.
// - Byte pairs form 16-bit counts; all registers reset to zero.
// - 13-bit mode uses high byte and five low bits; overflow sets flag.
// - 8-bit reload mode counts low byte, reloads from unchanged high byte.
// - In two-8-bit mode timer zero high byte owns timer one run and flag.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "timer01_consts.vh"
module dual_counter_timer_ctrl (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        ext_irq_zero_n,
	input  wire        ext_irq_one_n,
	input  wire        timer_zero_event_pin,
	input  wire        timer_one_event_pin,
	input  wire        ext_clock,
	input  wire        vector_timer_zero,
	input  wire        vector_timer_one,
	input  wire        vector_ext_zero,
	input  wire        vector_ext_one,
	output reg         timer_two_low_tick,
	output reg         timer_two_high_tick,
	output reg         timer_three_low_tick,
	output reg         timer_three_high_tick,
	output reg         timer_one_overflow_pulse
);

	reg  [7:0]  ctrl_q;
	reg  [7:0]  mode_q;
	reg  [7:0]  clksel_q;
	reg  [7:0]  aux_q;
	reg  [7:0]  t0_lo_q;
	reg  [7:0]  t0_hi_q;
	reg  [7:0]  t1_lo_q;
	reg  [7:0]  t1_hi_q;
	reg  [2:0]  s_e0_q;
	reg  [2:0]  s_e1_q;
	reg  [2:0]  s_p0_q;
	reg  [2:0]  s_p1_q;
	reg  [2:0]  s_xc_q;
	reg         e0_lvl_q;
	reg         e1_lvl_q;
	reg         p0_lvl_q;
	reg         p1_lvl_q;
	reg         xc_lvl_q;
	reg         p0_prev_q;
	reg         p1_prev_q;
	reg         xc_prev_q;
	reg         e0_act_prev_q;
	reg         e1_act_prev_q;
	reg  [5:0]  div12_q;
	reg  [5:0]  div4_q;
	reg  [5:0]  div48_q;
	reg  [2:0]  div8x_q;
	reg         aw_hold_q;
	reg         w_hold_q;
	reg  [31:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;

	//////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Wrap counter used by each system-clock divider.
	function [5:0] wrap_inc;
		input [5:0] cnt;
		input [5:0] div;
		begin
			if (cnt == div - 6'd1)
				wrap_inc = 6'd0;
			else
				wrap_inc = cnt + 6'd1;
		end
	endfunction

	// Byte register index from an AXI byte address; upper bits must be zero.
	function [8:0] reg_index;
		input [31:0] addr;
		begin
			if (addr[31:10] == 22'd0 && addr[1:0] == 2'b00)
				reg_index = {1'b1, addr[9:2]};
			else
				reg_index = 9'd0;
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Input synchronizers; a change counts once stages two and three agree.

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_e0_q   <= 3'b111;
			s_e1_q   <= 3'b111;
			s_p0_q   <= 3'b111;
			s_p1_q   <= 3'b111;
			s_xc_q   <= 3'b000;
			e0_lvl_q <= 1'b1;
			e1_lvl_q <= 1'b1;
			p0_lvl_q <= 1'b1;
			p1_lvl_q <= 1'b1;
			xc_lvl_q <= 1'b0;
		end else begin
			s_e0_q <= {s_e0_q[1:0], ext_irq_zero_n};
			s_e1_q <= {s_e1_q[1:0], ext_irq_one_n};
			s_p0_q <= {s_p0_q[1:0], timer_zero_event_pin};
			s_p1_q <= {s_p1_q[1:0], timer_one_event_pin};
			s_xc_q <= {s_xc_q[1:0], ext_clock};
			if (s_e0_q[1] == s_e0_q[2]) e0_lvl_q <= s_e0_q[2];
			if (s_e1_q[1] == s_e1_q[2]) e1_lvl_q <= s_e1_q[2];
			if (s_p0_q[1] == s_p0_q[2]) p0_lvl_q <= s_p0_q[2];
			if (s_p1_q[1] == s_p1_q[2]) p1_lvl_q <= s_p1_q[2];
			if (s_xc_q[1] == s_xc_q[2]) xc_lvl_q <= s_xc_q[2];
		end
	end

	// Polarity: polarity bit 0 means the input is active low.
	wire e0_active = aux_q[`B_E0_POL] ? e0_lvl_q : ~e0_lvl_q;
	wire e1_active = aux_q[`B_E1_POL] ? e1_lvl_q : ~e1_lvl_q;

	wire p0_fall = p0_prev_q & ~p0_lvl_q;
	wire p1_fall = p1_prev_q & ~p1_lvl_q;
	wire xc_rise = ~xc_prev_q & xc_lvl_q;
	wire e0_edge = e0_active & ~e0_act_prev_q;
	wire e1_edge = e1_active & ~e1_act_prev_q;

	//////////////////////////////////////////////////////////////////////////////
	// Prescaler: every divided clock is a one-cycle enable on aclk.

	always @(posedge aclk) begin
		if (!aresetn) begin
			div12_q       <= 6'd0;
			div4_q        <= 6'd0;
			div48_q       <= 6'd0;
			div8x_q       <= 3'd0;
			p0_prev_q     <= 1'b1;
			p1_prev_q     <= 1'b1;
			xc_prev_q     <= 1'b0;
			e0_act_prev_q <= 1'b0;
			e1_act_prev_q <= 1'b0;
		end else begin
			div12_q       <= wrap_inc(div12_q, `DIV_SYS12);
			div4_q        <= wrap_inc(div4_q, `DIV_SYS4);
			div48_q       <= wrap_inc(div48_q, `DIV_SYS48);
			if (xc_rise)
				div8x_q <= div8x_q + 3'd1;
			p0_prev_q     <= p0_lvl_q;
			p1_prev_q     <= p1_lvl_q;
			xc_prev_q     <= xc_lvl_q;
			e0_act_prev_q <= e0_active;
			e1_act_prev_q <= e1_active;
		end
	end

	wire tick12 = (div12_q == `DIV_SYS12 - 6'd1);
	wire tick4  = (div4_q == `DIV_SYS4 - 6'd1);
	wire tick48 = (div48_q == `DIV_SYS48 - 6'd1);
	// The external divide-by-eight tick is taken on the wrap of the synced count.
	wire tick8x = xc_rise & (div8x_q == `DIV_EXT8);

	reg presc_tick;
	always @* begin
		case (clksel_q[1:0])
			2'b00:   presc_tick = tick12;
			2'b01:   presc_tick = tick4;
			2'b10:   presc_tick = tick48;
			default: presc_tick = tick8x;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	// Count enables for timers zero and one.

	wire t0_split = (mode_q[1:0] == 2'b11);
	wire t0_clk_tick = clksel_q[`B_T0_SYS] ? 1'b1 : presc_tick;
	wire t1_clk_tick = clksel_q[`B_T1_SYS] ? 1'b1 : presc_tick;
	wire t0_src = mode_q[`B_T0_CNT] ? p0_fall : t0_clk_tick;
	// timer or event counting; split mode forbids external events for timer one
	wire t1_src = (mode_q[`B_T1_CNT] && !t0_split) ? p1_fall : t1_clk_tick;
	// run and gate for timer zero
	wire t0_en = ctrl_q[`B_T0_RUN] & (~mode_q[`B_T0_GATE] | e0_active);
	// gate for timer one; in split mode run control is through its mode
	wire t1_en = t0_split ? 1'b1 : (ctrl_q[`B_T1_RUN] & (~mode_q[`B_T1_GATE] | e1_active));
	wire t0_inc = t0_en & t0_src;
	// mode three leaves timer one still
	wire t1_inc = t1_en & t1_src & (mode_q[5:4] != 2'b11);
	// high byte of split timer zero runs from timer one run bit
	wire t0h_inc = t0_split & ctrl_q[`B_T1_RUN] & t0_clk_tick;

	// Next count and overflow for one timer in modes 0..2 (and split low byte).
	function [16:0] step;
		input [1:0] mode;
		input [7:0] lo;
		input [7:0] hi;
		reg   [16:0] sum;
		begin
			sum = 17'd0;
			case (mode)
				2'b00: begin
					sum = {4'd0, hi, lo[4:0]} + 17'd1;
					step = {sum[13], sum[12:5], lo[7:5], sum[4:0]};
				end
				2'b01: begin
					sum = {1'b0, hi, lo} + 17'd1;
					step = sum;
				end
				2'b10: begin
					if (lo == 8'hff)
						step = {1'b1, hi, hi};
					else
						step = {1'b0, hi, lo + 8'd1};
				end
				default: begin
					sum = {9'd0, lo} + 17'd1;
					step = {sum[8], hi, sum[7:0]};
				end
			endcase
		end
	endfunction

	wire [16:0] t0_next = step(mode_q[1:0], t0_lo_q, t0_hi_q);
	wire [16:0] t1_next = step(mode_q[5:4], t1_lo_q, t1_hi_q);
	wire        t0_ovf  = t0_inc & t0_next[16];
	wire        t0h_ovf = t0h_inc & (t0_hi_q == 8'hff);
	wire        t1_ovf  = t1_inc & t1_next[16];

	//////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path.

	// Commit only from the hold registers, so each write lands once with its response.
	wire [31:0] wa     = awaddr_q;
	wire [31:0] wd     = wdata_q;
	wire [3:0]  ws     = wstrb_q;
	wire        do_wr  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	wire [8:0]  widx   = reg_index(wa);
	wire        wr_any = do_wr & widx[8] & ws[0];
	wire        wr_ctl = wr_any & (widx[7:0] == `IDX_CTRL_STATUS);
	wire        wr_vec = wr_any & (widx[7:0] == `IDX_VECTOR_ACK);
	wire [7:0]  wb     = wd[7:0];

	// Vector acknowledges from pins or the acknowledge register.
	wire ack_t0 = vector_timer_zero | (wr_vec & wb[0]);
	wire ack_t1 = vector_timer_one | (wr_vec & wb[1]);
	wire ack_e0 = vector_ext_zero | (wr_vec & wb[2]);
	wire ack_e1 = vector_ext_one | (wr_vec & wb[3]);

	// Flags: set beats clear in the same cycle.
	reg [7:0] ctrl_d;
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_ctl)
			ctrl_d = wb;
		if (ack_t0) ctrl_d[`B_T0_OVF] = 1'b0;
		if (t0_ovf) ctrl_d[`B_T0_OVF] = 1'b1;
		// timer one flag, owned by split high byte
		if (ack_t1) ctrl_d[`B_T1_OVF] = 1'b0;
		if (t0_split ? t0h_ovf : t1_ovf) ctrl_d[`B_T1_OVF] = 1'b1;
		if (ack_e1 && ctrl_q[`B_E1_TYPE]) ctrl_d[`B_E1_FLAG] = 1'b0;
		if (ctrl_q[`B_E1_TYPE] ? e1_edge : e1_active) ctrl_d[`B_E1_FLAG] = 1'b1;
		if (ack_e0 && ctrl_q[`B_E0_TYPE]) ctrl_d[`B_E0_FLAG] = 1'b0;
		if (ctrl_q[`B_E0_TYPE] ? e0_edge : e0_active) ctrl_d[`B_E0_FLAG] = 1'b1;
	end

	// registers and counts, reset to zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q   <= `RESET_BYTE;
			mode_q   <= `RESET_BYTE;
			clksel_q <= `RESET_BYTE;
			aux_q    <= `RESET_BYTE;
			t0_lo_q  <= `RESET_BYTE;
			t0_hi_q  <= `RESET_BYTE;
			t1_lo_q  <= `RESET_BYTE;
			t1_hi_q  <= `RESET_BYTE;
		end else begin
			ctrl_q <= ctrl_d;
			if (wr_any && widx[7:0] == `IDX_MODE_CFG) mode_q <= wb;
			if (wr_any && widx[7:0] == `IDX_CLK_SEL) clksel_q <= wb;
			if (wr_any && widx[7:0] == `IDX_AUX_CFG) aux_q <= {2'b00, wb[5:0]};
			// timer zero count per mode; software write wins
			if (wr_any && widx[7:0] == `IDX_T0_LOW)
				t0_lo_q <= wb;
			else if (t0_inc)
				t0_lo_q <= t0_next[7:0];
			if (wr_any && widx[7:0] == `IDX_T0_HIGH)
				t0_hi_q <= wb;
			else if (t0_split ? t0h_inc : t0_inc)
				t0_hi_q <= t0_split ? t0_hi_q + 8'd1 : t0_next[15:8];
			if (wr_any && widx[7:0] == `IDX_T1_LOW)
				t1_lo_q <= wb;
			else if (t1_inc)
				t1_lo_q <= t1_next[7:0];
			if (wr_any && widx[7:0] == `IDX_T1_HIGH)
				t1_hi_q <= wb;
			else if (t1_inc)
				t1_hi_q <= t1_next[15:8];
		end
	end

	// Write handshake: address and data taken in either order, then one response.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 32'h0;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid & ~do_wr;
			s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid & ~do_wr;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= widx[8] ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path; unmapped reads return zero with SLVERR.

	wire [8:0] ridx = reg_index(s_axi_araddr);
	reg  [7:0] rbyte;
	reg        rhit;
	always @* begin
		rhit = ridx[8];
		case (ridx[7:0])
			`IDX_CTRL_STATUS: rbyte = ctrl_q;
			`IDX_MODE_CFG:    rbyte = mode_q;
			`IDX_T0_LOW:      rbyte = t0_lo_q;
			`IDX_T1_LOW:      rbyte = t1_lo_q;
			`IDX_T0_HIGH:     rbyte = t0_hi_q;
			`IDX_T1_HIGH:     rbyte = t1_hi_q;
			`IDX_CLK_SEL:     rbyte = clksel_q;
			`IDX_AUX_CFG:     rbyte = aux_q;
			`IDX_VECTOR_ACK:  rbyte = 8'h00;
			default: begin
				rbyte = 8'h00;
				rhit  = 1'b0;
			end
		endcase
	end

	// Reads are taken only when no answer is pending, so rdata stays put.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h0, rbyte};
				s_axi_rresp  <= rhit ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Timer two/three clock enables for the datapaths outside this block.

	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_two_low_tick       <= 1'b0;
			timer_two_high_tick      <= 1'b0;
			timer_three_low_tick     <= 1'b0;
			timer_three_high_tick    <= 1'b0;
			timer_one_overflow_pulse <= 1'b0;
		end else begin
			timer_two_low_tick <= clksel_q[`B_T2_LO] |
				(aux_q[`B_T2_XCLK] ? tick8x : tick12);
			// timer two high clock select in split only
			timer_two_high_tick <= (clksel_q[`B_T2_HI] & aux_q[`B_T2_SPLIT]) |
				(aux_q[`B_T2_XCLK] ? tick8x : tick12);
			timer_three_low_tick <= clksel_q[`B_T3_LO] |
				(aux_q[`B_T3_XCLK] ? tick8x : tick12);
			// timer three high clock select in split only
			timer_three_high_tick <= (clksel_q[`B_T3_HI] & aux_q[`B_T3_SPLIT]) |
				(aux_q[`B_T3_XCLK] ? tick8x : tick12);
			// Timer one still overflows for baud use even when its flag is taken.
			timer_one_overflow_pulse <= t1_ovf;
		end
	end

endmodule // dual_counter_timer_ctrl

// ===== verif/dual_counter_timer_ctrl_sva.sv
`timescale 1ns/10ps
module timer_ctrl_chk (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        timer_one_overflow_pulse
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////////
	// responses hold, handshakes are answered, write codes are legal, reset is quiet
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before bready");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before rready");
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held longer than one cycle");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not offered after address taken");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write response late");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
		else $error("illegal write response code");
	chk_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !timer_one_overflow_pulse)
		else $error("outputs active right after reset");

	// The main traffic kinds are seen at least once.
	cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_overflow: cover property (timer_one_overflow_pulse);
endmodule // timer_ctrl_chk

bind dual_counter_timer_ctrl timer_ctrl_chk chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .timer_one_overflow_pulse(timer_one_overflow_pulse));

// ===== verif/cpu_bus_model.sv
`timescale 1ns/10ps
module cpu_bus_model (
	input  logic        aclk,
	output logic [31:0] awaddr,
	output logic        awvalid,
	input  logic        awready,
	output logic [31:0] wdata,
	output logic [3:0]  wstrb,
	output logic        wvalid,
	input  logic        wready,
	input  logic [1:0]  bresp,
	input  logic        bvalid,
	output logic        bready,
	output logic [31:0] araddr,
	output logic        arvalid,
	input  logic        arready,
	input  logic [31:0] rdata,
	input  logic [1:0]  rresp,
	input  logic        rvalid,
	output logic        rready,
	output logic [3:0]  vector
);
	// Idle bus at time zero so the slave never sees a stray request.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, vector} = '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Each channel drops its valid only at the edge where its ready was seen.
	task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	// Read address is released on its handshake; data is taken when rvalid is seen.
	task automatic rd(input logic [31:0] a, output logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic vec(input int which);
		@(posedge aclk);
		vector[which] <= 1'b1;
		@(posedge aclk);
		vector[which] <= 1'b0;
	endtask
endmodule // cpu_bus_model

// ===== verif/test_dual_counter_timer_ctrl.sv
`timescale 1ns/10ps
`include "timer01_consts.vh"
module test_dual_counter_timer_ctrl;
	logic        aclk, aresetn, ext_irq_zero_n, ext_irq_one_n, ev0, ev1, ext_clock;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb, vector;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, t2l, t2h, t3l, t3h, ovf1, seen;
	logic [7:0]  d;
	int          mismatches, checks_done, i;
	logic [7:0]  rst_idx [7] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8f};
	logic [7:0]  t_idx [9] = '{8'h89, 8'h8f, 8'h8c, 8'h8d, 8'h8a, 8'h8b, 8'h90, 8'h91, 8'ha0};
	logic [7:0]  t_wd [9] = '{8'h5a, 8'hf3, 8'ha5, 8'h3c, 8'h11, 8'h7e, 8'h0c, 8'h0f, 8'hff};
	logic [7:0]  t_ex [9] = '{8'h5a, 8'hf3, 8'ha5, 8'h3c, 8'h11, 8'h7e, 8'h0c, 8'h00, 8'h00};
	logic [1:0]  t_rs [9] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b10};
	int          pre_exp [4] = '{40, 121, 10, 10};

	dual_counter_timer_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_irq_zero_n(ext_irq_zero_n), .ext_irq_one_n(ext_irq_one_n),
		.timer_zero_event_pin(ev0), .timer_one_event_pin(ev1), .ext_clock(ext_clock),
		.vector_timer_zero(vector[0]), .vector_timer_one(vector[1]), .vector_ext_zero(vector[2]),
		.vector_ext_one(vector[3]), .timer_two_low_tick(t2l), .timer_two_high_tick(t2h),
		.timer_three_low_tick(t3l), .timer_three_high_tick(t3h), .timer_one_overflow_pulse(ovf1));
	cpu_bus_model cpu_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .vector(vector));

	// Free-running 10 MHz system clock.
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers sit on word boundaries, four bytes per index.
	function automatic logic [31:0] addr_of(input logic [7:0] idx);
		return {22'h0, idx, 2'b00};
	endfunction
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
		cpu_u.wr(addr_of(idx), v, r);
	endtask
	task automatic reg_rd(input logic [7:0] idx);
		cpu_u.rd(addr_of(idx), d, r);
	endtask
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask
	// The prescaler free-runs, so its phase against the run window is a tolerance.
	task automatic chk_near(input string n, input int e, input logic [7:0] g);
		checks_done++;
		if ($isunknown(g) || g + 2 < e || g > e + 2) begin
			mismatches++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// A hang is cut short well after the expected run length.
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		$display("[FAIL] watchdog expected finish seen timeout");
		stop_test;
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0;
		{ext_irq_zero_n, ext_irq_one_n, ev0, ev1, ext_clock} = 5'b11110;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 7; i++) begin
			reg_rd(rst_idx[i]);
			chk_byte("reset value", 8'h00, d);
		end
		$display("test reset done");
		// Table rows cover read/write places, write-only acks and an unmapped place.
		// Writes inside the register window always answer OKAY; only reads refuse.
		for (i = 0; i < 9; i++) begin
			cpu_u.wr(addr_of(t_idx[i]), t_wd[i], r);
			chk_resp("write resp", 2'b00, r);
			reg_rd(t_idx[i]);
			chk_resp("read resp", t_rs[i], r);
			chk_byte("read back", t_ex[i], d);
		end
		chk_byte("tick enables", 8'h0a, {4'h0, t2l, t2h, t3l, t3h});
		$display("test table done");
		// Auto-reload on the system clock, then stop and vector.
		reg_wr(`IDX_MODE_CFG, 8'h02);
		reg_wr(`IDX_CLK_SEL, 8'h04);
		reg_wr(`IDX_T0_HIGH, 8'hf0);
		reg_wr(`IDX_T0_LOW, 8'hf0);
		reg_wr(`IDX_CTRL_STATUS, 8'h10);
		repeat (40) @(posedge aclk);
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("overflow while running", 8'h30, d);
		reg_wr(`IDX_CTRL_STATUS, 8'h20);
		reg_rd(`IDX_T0_HIGH);
		chk_byte("reload byte kept", 8'hf0, d);
		reg_rd(`IDX_T0_LOW);
		chk_byte("low in reload range", 8'h0f, {4'h0, d[7:4]});
		cpu_u.vec(0);
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("flag after vector", 8'h00, d);
		$display("test reload done");
		// Gate holds the count until the level input goes active.
		reg_wr(`IDX_T0_HIGH, 8'h00);
		reg_wr(`IDX_T0_LOW, 8'h00);
		reg_wr(`IDX_MODE_CFG, 8'h0a);
		reg_wr(`IDX_CTRL_STATUS, 8'h10);
		repeat (20) @(posedge aclk);
		reg_rd(`IDX_T0_LOW);
		chk_byte("gated count", 8'h00, d);
		ext_irq_zero_n <= 1'b0;
		repeat (20) @(posedge aclk);
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("level flag", 8'h12, d);
		reg_rd(`IDX_T0_LOW);
		chk_byte("count moved", 8'h01, {7'h0, d != 8'h00});
		ext_irq_zero_n <= 1'b1;
		repeat (10) @(posedge aclk);
		reg_wr(`IDX_CTRL_STATUS, 8'h00);
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("level flag cleared", 8'h00, d);
		$display("test gate done");
		// Edge-triggered input latches a short pulse until vectoring.
		reg_wr(`IDX_CTRL_STATUS, 8'h04);
		ext_irq_one_n <= 1'b0;
		repeat (3) @(posedge aclk);
		ext_irq_one_n <= 1'b1;
		repeat (10) @(posedge aclk);
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("edge flag", 8'h0c, d);
		cpu_u.vec(3);
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("edge flag vectored", 8'h04, d);
		$display("test edge done");
		// Falling edges on the event pin, each level held three cycles.
		reg_wr(`IDX_MODE_CFG, 8'h05);
		reg_wr(`IDX_T0_LOW, 8'h00);
		reg_wr(`IDX_CTRL_STATUS, 8'h10);
		repeat (5) begin
			repeat (3) @(posedge aclk);
			ev0 <= 1'b0;
			repeat (3) @(posedge aclk);
			ev0 <= 1'b1;
		end
		repeat (10) @(posedge aclk);
		reg_rd(`IDX_T0_LOW);
		chk_byte("event count", 8'h05, d);
		$display("test events done");
		// Thirteen-bit wrap from 0x1ff8 on the system clock.
		reg_wr(`IDX_MODE_CFG, 8'h00);
		reg_wr(`IDX_CLK_SEL, 8'h08);
		reg_wr(`IDX_T1_LOW, 8'h18);
		reg_wr(`IDX_T1_HIGH, 8'hff);
		reg_wr(`IDX_CTRL_STATUS, 8'h40);
		seen = 1'b0;
		repeat (20) begin
			@(posedge aclk);
			if (ovf1 === 1'b1) seen = 1'b1;
		end
		chk_byte("overflow pulse", 8'h01, {7'h0, seen});
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("timer one flag", 8'hc0, d);
		reg_wr(`IDX_CTRL_STATUS, 8'h80);
		reg_rd(`IDX_T1_HIGH);
		chk_byte("wrapped high byte", 8'h00, d);
		cpu_u.vec(1);
		reg_rd(`IDX_CTRL_STATUS);
		chk_byte("timer one vectored", 8'h00, d);
		$display("test wrap done");
		// Each prescale counted over a fixed window; the external clock toggles every 3 cycles.
		reg_wr(`IDX_MODE_CFG, 8'h01);
		for (i = 0; i < 4; i++) begin
			reg_wr(`IDX_CLK_SEL, i[7:0]);
			reg_wr(`IDX_T0_LOW, 8'h00);
			reg_wr(`IDX_CTRL_STATUS, 8'h10);
			repeat (160) begin
				repeat (3) @(posedge aclk);
				ext_clock <= ~ext_clock;
			end
			reg_wr(`IDX_CTRL_STATUS, 8'h00);
			reg_rd(`IDX_T0_LOW);
			chk_near("prescaled count", pre_exp[i], d);
		end
		$display("test prescale done");
		stop_test;
	end
endmodule // test_dual_counter_timer_ctrl
